// [hw/dpsc_top.sv]
// Top of the drive power state control block: object access port,
// command word, report word, error code and the power state machine.
// Assumes object requests and status inputs come from CLK logic,
// except BUS_SYNC which arrives from another domain.
`timescale 1ns/1ps

module dpsc_top (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        OBJ_REQ,
    input  wire logic        OBJ_WRITE,
    input  wire logic [15:0] OBJ_INDEX,
    input  wire logic [15:0] OBJ_WDATA,
    output logic             OBJ_ACK,
    output logic             OBJ_ERR,
    output logic      [15:0] OBJ_RDATA,
    input  wire logic        ERR_LOG_VALID,
    input  wire logic [31:0] ERR_LOG_ENTRY,
    input  wire logic        FAULT_IN,
    input  wire logic        FAULT_CLEARABLE,
    input  wire logic        REACTION_DONE,
    input  wire logic        STOP_DONE,
    input  wire logic        VOLTAGE_OK,
    input  wire logic        BUS_SYNC,
    input  wire logic        WARNING_IN,
    input  wire logic        GOAL_REACHED,
    input  wire logic        LIMIT_HIT,
    input  wire logic        CLOSED_LOOP_ON,
    input  wire logic  [7:0] OP_MODE,
    input  wire logic  [1:0] MODE_STATUS,
    output logic             HALT_REQ,
    output logic       [3:0] MODE_CTRL,
    output logic      [15:0] STATE_REPORT,
    output logic       [2:0] POWER_STATE
);
    typedef struct packed {
        logic [15:0] cmd;     // Held command word
        logic [15:0] report;  // Registered report word
        logic [15:0] rdata;   // Read answer
        logic        ack;     // Answer strobe
        logic        err;     // Unmapped or read-only write
        logic        halt;    // Halt towards the profile logic
        logic  [3:0] mctl;    // Mode dependent command bits
        logic        sync1;   // Bus lock first stage
        logic        sync2;   // Bus lock second stage
    } dpsc_top_s;

    dpsc_top_s             cur;       // Registered state
    dpsc_top_s             next_cur;  // Its next value
    logic [15:0]           report;    // Report word from current state
    logic                  halt_ok;   // Mode honours a halt
    dpsc_pkg::dpsc_state_e st;        // Power state seen from the machine

    dpsc_if link ();

    // Feed the machine and the error latch
    assign link.cmd_word   = cur.cmd;
    assign link.fault_in   = FAULT_IN;
    assign link.clearable  = FAULT_CLEARABLE;
    assign link.react_done = REACTION_DONE;
    assign link.stop_done  = STOP_DONE;
    assign link.log_valid  = ERR_LOG_VALID;
    assign link.log_entry  = ERR_LOG_ENTRY;
    assign st              = link.state;

    dpsc_fsm u_fsm (
        .CLK (CLK),
        .RST (RST),
        .bus (link)
    );

    dpsc_err u_err (
        .CLK (CLK),
        .RST (RST),
        .bus (link)
    );

    // Halt only means something in the listed motion modes
    function automatic logic halt_mode(input logic [7:0] m);
        return m == dpsc_pkg::MODE_PROF_POS || m == dpsc_pkg::MODE_VELOCITY
            || m == dpsc_pkg::MODE_PROF_VEL || m == dpsc_pkg::MODE_PROF_TRQ
            || m == dpsc_pkg::MODE_INTERP;
    endfunction : halt_mode

    assign halt_ok = halt_mode(OP_MODE);

    // Report word built from the power state and live inputs
    always_comb
    begin
        report = 16'h0000;
        unique case (st)
            dpsc_pkg::ST_NOT_READY:
                report[3:0] = 4'h0;
            dpsc_pkg::ST_SW_ON_DIS:
            begin
                report[dpsc_pkg::SW_SO_DISABLE] = 1'b1;
                report[3:0]                     = 4'h0;
            end
            dpsc_pkg::ST_READY:
                report[3:0] = 4'h1;
            dpsc_pkg::ST_SWITCHED_ON:
                report[3:0] = 4'h3;
            dpsc_pkg::ST_OP_ENABLED:
                report[3:0] = 4'h7;
            dpsc_pkg::ST_QUICK_STOP:
                report[3:0] = 4'h7;
            dpsc_pkg::ST_FAULT_REACT:
                report[3:0] = 4'hf;
            dpsc_pkg::ST_FAULT:
                report[3:0] = 4'h8;
        endcase
        // Quick stop flag reads low while stopping and in switch on disabled
        report[dpsc_pkg::SW_QUICK_STOP] = (st != dpsc_pkg::ST_QUICK_STOP)
                                          && (st != dpsc_pkg::ST_SW_ON_DIS);
        report[dpsc_pkg::SW_VOLTAGE]   = VOLTAGE_OK;
        report[dpsc_pkg::SW_WARNING]   = WARNING_IN;
        report[dpsc_pkg::SW_BUS_LOCK]  = cur.sync2;
        report[dpsc_pkg::SW_HOST_CTRL] = 1'b1;
        report[dpsc_pkg::SW_GOAL]      = GOAL_REACHED;
        report[dpsc_pkg::SW_LIMIT]     = LIMIT_HIT;
        report[dpsc_pkg::SW_MODE_HI:dpsc_pkg::SW_MODE_LO] = MODE_STATUS;
        report[dpsc_pkg::SW_CLOSED]    = CLOSED_LOOP_ON
                                         && st == dpsc_pkg::ST_OP_ENABLED;
    end

    // Object access, command outputs and bus lock synchroniser
    always_comb
    begin
        next_cur       = cur;
        next_cur.ack   = OBJ_REQ;
        next_cur.err   = 1'b0;
        next_cur.rdata = 16'h0000;
        next_cur.sync1 = BUS_SYNC;
        next_cur.sync2 = cur.sync1;
        next_cur.report = report;
        if (OBJ_REQ)
        begin
            unique case (OBJ_INDEX)
                dpsc_pkg::IDX_LAST_ERROR:
                begin
                    // Read only; a write is refused
                    next_cur.err   = OBJ_WRITE;
                    next_cur.rdata = OBJ_WRITE ? 16'h0000 : link.err_code;
                end
                dpsc_pkg::IDX_STATE_CMD:
                begin
                    if (OBJ_WRITE)
                        next_cur.cmd = OBJ_WDATA;
                    else
                        next_cur.rdata = cur.cmd;
                end
                dpsc_pkg::IDX_STATE_REPORT:
                begin
                    next_cur.err   = OBJ_WRITE;
                    next_cur.rdata = OBJ_WRITE ? 16'h0000 : cur.report;
                end
                default:
                    // Unknown index answers with an error and zero data
                    next_cur.err = 1'b1;
            endcase
        end
        // Mode bits pass straight to the mode logic, which owns their meaning
        next_cur.mctl = {cur.cmd[dpsc_pkg::CW_MODE_TOP],
                         cur.cmd[dpsc_pkg::CW_MODE_HI:dpsc_pkg::CW_MODE_LO]};
        next_cur.halt = cur.cmd[dpsc_pkg::CW_HALT] && halt_ok;
    end

    // State register
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            cur.cmd    <= dpsc_pkg::RST_CMD_WORD;
            cur.report <= dpsc_pkg::RST_REPORT;
            cur.rdata  <= 16'h0000;
            cur.ack    <= 1'b0;
            cur.err    <= 1'b0;
            cur.halt   <= 1'b0;
            cur.mctl   <= 4'h0;
            cur.sync1  <= 1'b0;
            cur.sync2  <= 1'b0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // Outputs, all from flops; the state code from the machine's state register
    assign OBJ_ACK      = cur.ack;
    assign OBJ_ERR      = cur.err;
    assign OBJ_RDATA    = cur.rdata;
    assign HALT_REQ     = cur.halt;
    assign MODE_CTRL    = cur.mctl;
    assign STATE_REPORT = cur.report;
    assign POWER_STATE  = st;

    // Checks share CLK and are idle while RST is high
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    // Object port and command storage
    a_cmd_write: assert property (OBJ_REQ && OBJ_WRITE
        && OBJ_INDEX == dpsc_pkg::IDX_STATE_CMD |=> cur.cmd == $past(OBJ_WDATA))
        else $error("command word not stored");
    a_obj_answer: assert property (OBJ_REQ |=> OBJ_ACK)
        else $error("no answer to request");

    // Power state transitions from whole commands and from a live fault
    a_switch_on: assert property (st == dpsc_pkg::ST_READY
        && cur.cmd[3:0] == 4'h7 && !FAULT_IN |=> st == dpsc_pkg::ST_SWITCHED_ON)
        else $error("switch on not taken");
    a_enable_volt: assert property (st == dpsc_pkg::ST_SW_ON_DIS
        && cur.cmd[2:0] == 3'h6 && !FAULT_IN |=> st == dpsc_pkg::ST_READY)
        else $error("voltage enable not taken");
    a_quick_stop: assert property (st == dpsc_pkg::ST_OP_ENABLED
        && cur.cmd[2:1] == 2'h1 && !FAULT_IN |=> st == dpsc_pkg::ST_QUICK_STOP)
        else $error("quick stop not taken");
    a_run_enable: assert property (st == dpsc_pkg::ST_SWITCHED_ON
        && cur.cmd[3:0] == 4'hf && !FAULT_IN |=> st == dpsc_pkg::ST_OP_ENABLED)
        else $error("run enable not taken");
    a_fault_entry: assert property (FAULT_IN && st != dpsc_pkg::ST_FAULT
        && st != dpsc_pkg::ST_FAULT_REACT |=> st == dpsc_pkg::ST_FAULT_REACT)
        else $error("fault reaction not entered");

    // Halt gating by operating mode
    a_halt_mode: assert property (cur.cmd[dpsc_pkg::CW_HALT] && halt_ok
        |=> HALT_REQ)
        else $error("halt not raised");
    a_halt_block: assert property (!halt_ok |=> !HALT_REQ)
        else $error("halt in wrong mode");

    // Report word encodings, one cycle behind the state
    a_notready_code: assert property (st == dpsc_pkg::ST_NOT_READY
        |=> !STATE_REPORT[6] && STATE_REPORT[3:0] == 4'h0)
        else $error("not ready encoding wrong");
    a_disabled_code: assert property (st == dpsc_pkg::ST_SW_ON_DIS
        |=> STATE_REPORT[6] && STATE_REPORT[3:0] == 4'h0)
        else $error("disabled encoding wrong");
    a_ready_code: assert property (st == dpsc_pkg::ST_READY
        |=> STATE_REPORT[6:5] == 2'h1 && STATE_REPORT[3:0] == 4'h1)
        else $error("ready encoding wrong");
    a_switched_code: assert property (st == dpsc_pkg::ST_SWITCHED_ON
        |=> STATE_REPORT[6:5] == 2'h1 && STATE_REPORT[3:0] == 4'h3)
        else $error("switched on encoding wrong");
    a_run_code: assert property (st == dpsc_pkg::ST_OP_ENABLED
        |=> STATE_REPORT[6:5] == 2'h1 && STATE_REPORT[3:0] == 4'h7)
        else $error("run encoding wrong");
    a_stop_code: assert property (st == dpsc_pkg::ST_QUICK_STOP
        |=> STATE_REPORT[6:5] == 2'h0 && STATE_REPORT[3:0] == 4'h7)
        else $error("quick stop encoding wrong");
    a_react_code: assert property (st == dpsc_pkg::ST_FAULT_REACT
        |=> !STATE_REPORT[6] && STATE_REPORT[3:0] == 4'hf)
        else $error("fault reaction encoding wrong");
    a_fault_code: assert property (st == dpsc_pkg::ST_FAULT
        |=> !STATE_REPORT[6] && STATE_REPORT[3:0] == 4'h8)
        else $error("fault encoding wrong");

    // Live flags; the first edge after reset still shows the reset word
    a_host_flag: assert property (!$past(RST)
        |-> STATE_REPORT[dpsc_pkg::SW_HOST_CTRL])
        else $error("host flag not one");
    a_limit_flag: assert property (!$past(RST)
        |-> STATE_REPORT[dpsc_pkg::SW_LIMIT] == $past(LIMIT_HIT))
        else $error("limit flag not live");
    a_live_flags: assert property (!$past(RST)
        |-> STATE_REPORT[dpsc_pkg::SW_VOLTAGE] == $past(VOLTAGE_OK)
        && STATE_REPORT[dpsc_pkg::SW_WARNING] == $past(WARNING_IN)
        && STATE_REPORT[dpsc_pkg::SW_GOAL] == $past(GOAL_REACHED))
        else $error("live flags not reported");
    // Two synchroniser stages and the report flop lie between pin and word
    a_bus_lock: assert property ($rose(BUS_SYNC) ##1 BUS_SYNC
        |-> ##2 STATE_REPORT[dpsc_pkg::SW_BUS_LOCK])
        else $error("bus lock late");
    a_closed_loop: assert property (STATE_REPORT[dpsc_pkg::SW_CLOSED]
        |-> $past(st) == dpsc_pkg::ST_OP_ENABLED)
        else $error("closed loop outside run");

    // Main scenarios
    c_run: cover property (st == dpsc_pkg::ST_OP_ENABLED);
    c_qstop: cover property (st == dpsc_pkg::ST_QUICK_STOP);
    c_fault_clr: cover property (st == dpsc_pkg::ST_FAULT ##1 st == dpsc_pkg::ST_SW_ON_DIS);
    c_bad_index: cover property (OBJ_ACK && OBJ_ERR);
    c_halt: cover property (HALT_REQ);
endmodule : dpsc_top

// [hw/dpsc_pkg.sv]
// Shared constants and types for the drive power state control block.
// Assumes every user is clocked by one CLK and reset by one RST.
package dpsc_pkg;

    // Object indices as seen on the object access port
    localparam logic [15:0] IDX_LAST_ERROR   = 16'h603f;
    localparam logic [15:0] IDX_STATE_CMD    = 16'h6040;
    localparam logic [15:0] IDX_STATE_REPORT = 16'h6041;

    // Reset values
    localparam logic [15:0] RST_ERROR_CODE = 16'h0000;
    localparam logic [15:0] RST_CMD_WORD   = 16'h0000;
    localparam logic [15:0] RST_REPORT     = 16'h0000;

    // Command word bit positions
    localparam int CW_SWITCH_ON  = 0;
    localparam int CW_EN_VOLTAGE = 1;
    localparam int CW_QUICK_STOP = 2;
    localparam int CW_RUN_ENABLE = 3;
    localparam int CW_CLR_FAULT  = 7;
    localparam int CW_HALT       = 8;
    localparam int CW_MODE_LO    = 4;
    localparam int CW_MODE_HI    = 6;
    localparam int CW_MODE_TOP   = 9;

    // Report word bit positions
    localparam int SW_READY      = 0;
    localparam int SW_SWITCHED   = 1;
    localparam int SW_OP_ENABLED = 2;
    localparam int SW_FAULT      = 3;
    localparam int SW_VOLTAGE    = 4;
    localparam int SW_QUICK_STOP = 5;
    localparam int SW_SO_DISABLE = 6;
    localparam int SW_WARNING    = 7;
    localparam int SW_BUS_LOCK   = 8;
    localparam int SW_HOST_CTRL  = 9;
    localparam int SW_GOAL       = 10;
    localparam int SW_LIMIT      = 11;
    localparam int SW_MODE_LO    = 12;
    localparam int SW_MODE_HI    = 13;
    localparam int SW_CLOSED     = 15;

    // Operating mode codes that honour a halt
    localparam logic [7:0] MODE_PROF_POS = 8'h01;
    localparam logic [7:0] MODE_VELOCITY = 8'h02;
    localparam logic [7:0] MODE_PROF_VEL = 8'h03;
    localparam logic [7:0] MODE_PROF_TRQ = 8'h04;
    localparam logic [7:0] MODE_INTERP   = 8'h07;

    // Power states
    typedef enum logic [2:0] {
        ST_NOT_READY   = 3'h0,
        ST_SW_ON_DIS   = 3'h1,
        ST_READY       = 3'h2,
        ST_SWITCHED_ON = 3'h3,
        ST_OP_ENABLED  = 3'h4,
        ST_QUICK_STOP  = 3'h5,
        ST_FAULT_REACT = 3'h6,
        ST_FAULT       = 3'h7
    } dpsc_state_e;

endpackage : dpsc_pkg

// [hw/dpsc_if.sv]
// Carrier between the top level and its state machine and error latch.
// Assumes all three ends share CLK and RST.
`timescale 1ns/1ps
interface dpsc_if;
    logic [15:0]          cmd_word;    // Held command word
    logic                 fault_in;    // Fault condition level
    logic                 clearable;   // Fault may be cleared
    logic                 react_done;  // Fault reaction finished
    logic                 stop_done;   // Quick stop ramp finished
    logic                 log_valid;   // New error history entry
    logic [31:0]          log_entry;   // That entry
    dpsc_pkg::dpsc_state_e state;      // Current power state
    logic [15:0]          err_code;    // Last error code

    modport top (output cmd_word, fault_in, clearable, react_done, stop_done,
                 output log_valid, log_entry, input state, err_code);
    modport fsm (input cmd_word, fault_in, clearable, react_done, stop_done,
                 output state);
    modport err (input log_valid, log_entry, output err_code);
endinterface : dpsc_if

// [hw/dpsc_err.sv]
// Last error code latch.
// Assumes log_valid is a one-cycle pulse on CLK.
`timescale 1ns/1ps
module dpsc_err (
    input wire logic CLK,
    input wire logic RST,
    dpsc_if.err      bus
);
    typedef struct packed {
        logic [15:0] code;   // Low half of newest entry
    } dpsc_err_s;

    dpsc_err_s cur;
    dpsc_err_s next_cur;

    // Keep only the low sixteen bits of the newest history entry
    always_comb
    begin
        next_cur = cur;
        if (bus.log_valid)
        begin
            next_cur.code = bus.log_entry[15:0];
        end
    end

    // State register
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            cur.code <= dpsc_pkg::RST_ERROR_CODE;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign bus.err_code = cur.code;

    a_err_capture: assert property (@(posedge CLK) disable iff (RST)
        bus.log_valid |=> bus.err_code == $past(bus.log_entry[15:0]))
        else $error("error code not captured");
endmodule : dpsc_err

// [hw/dpsc_fsm.sv]
// Power state machine driven by the command word.
// Assumes the command word is held stable between host writes.
`timescale 1ns/1ps
module dpsc_fsm (
    input wire logic CLK,
    input wire logic RST,
    dpsc_if.fsm      bus
);
    typedef enum logic [2:0] {
        CMD_DISABLE_V = 3'h0,
        CMD_QSTOP     = 3'h1,
        CMD_SHUTDOWN  = 3'h2,
        CMD_SWITCH_ON = 3'h3,
        CMD_RUN       = 3'h4
    } dpsc_cmd_e;

    typedef struct packed {
        dpsc_pkg::dpsc_state_e st;   // Power state
        logic                  clr;  // Previous clear request bit
    } dpsc_fsm_s;

    dpsc_fsm_s cur;
    dpsc_fsm_s next_cur;
    dpsc_cmd_e cmd;
    logic      clr_edge;

    // Four request bits read as one command, voltage removal first
    function automatic dpsc_cmd_e decode(input logic [15:0] cw);
        if (!cw[dpsc_pkg::CW_EN_VOLTAGE])
            return CMD_DISABLE_V;
        else if (!cw[dpsc_pkg::CW_QUICK_STOP])
            return CMD_QSTOP;
        else if (!cw[dpsc_pkg::CW_SWITCH_ON])
            return CMD_SHUTDOWN;
        else if (cw[dpsc_pkg::CW_RUN_ENABLE])
            return CMD_RUN;
        else
            return CMD_SWITCH_ON;
    endfunction : decode

    assign cmd      = decode(bus.cmd_word);
    assign clr_edge = bus.cmd_word[dpsc_pkg::CW_CLR_FAULT] && !cur.clr;

    // Next state; a live fault beats any host command
    always_comb
    begin
        next_cur     = cur;
        next_cur.clr = bus.cmd_word[dpsc_pkg::CW_CLR_FAULT];
        if (bus.fault_in && cur.st != dpsc_pkg::ST_FAULT_REACT
            && cur.st != dpsc_pkg::ST_FAULT)
        begin
            next_cur.st = dpsc_pkg::ST_FAULT_REACT;
        end
        else
        begin
            unique case (cur.st)
                dpsc_pkg::ST_NOT_READY:
                    next_cur.st = dpsc_pkg::ST_SW_ON_DIS;
                dpsc_pkg::ST_SW_ON_DIS:
                    if (cmd == CMD_SHUTDOWN || cmd == CMD_SWITCH_ON || cmd == CMD_RUN)
                        next_cur.st = dpsc_pkg::ST_READY;
                dpsc_pkg::ST_READY:
                    if (cmd == CMD_DISABLE_V || cmd == CMD_QSTOP)
                        next_cur.st = dpsc_pkg::ST_SW_ON_DIS;
                    else if (cmd == CMD_SWITCH_ON)
                        next_cur.st = dpsc_pkg::ST_SWITCHED_ON;
                    else if (cmd == CMD_RUN)
                        next_cur.st = dpsc_pkg::ST_OP_ENABLED;
                dpsc_pkg::ST_SWITCHED_ON:
                    if (cmd == CMD_DISABLE_V || cmd == CMD_QSTOP)
                        next_cur.st = dpsc_pkg::ST_SW_ON_DIS;
                    else if (cmd == CMD_SHUTDOWN)
                        next_cur.st = dpsc_pkg::ST_READY;
                    else if (cmd == CMD_RUN)
                        next_cur.st = dpsc_pkg::ST_OP_ENABLED;
                dpsc_pkg::ST_OP_ENABLED:
                    if (cmd == CMD_DISABLE_V)
                        next_cur.st = dpsc_pkg::ST_SW_ON_DIS;
                    else if (cmd == CMD_QSTOP)
                        next_cur.st = dpsc_pkg::ST_QUICK_STOP;
                    else if (cmd == CMD_SHUTDOWN)
                        next_cur.st = dpsc_pkg::ST_READY;
                    else if (cmd == CMD_SWITCH_ON)
                        next_cur.st = dpsc_pkg::ST_SWITCHED_ON;
                dpsc_pkg::ST_QUICK_STOP:
                    if (cmd == CMD_DISABLE_V || bus.stop_done)
                        next_cur.st = dpsc_pkg::ST_SW_ON_DIS;
                dpsc_pkg::ST_FAULT_REACT:
                    if (bus.react_done)
                        next_cur.st = dpsc_pkg::ST_FAULT;
                dpsc_pkg::ST_FAULT:
                    // A fault still present wins over the clear
                    if (clr_edge && bus.clearable && !bus.fault_in)
                        next_cur.st = dpsc_pkg::ST_SW_ON_DIS;
            endcase
        end
    end

    // State register
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            cur.st  <= dpsc_pkg::ST_NOT_READY;
            cur.clr <= 1'b0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign bus.state = cur.st;

    a_fault_clear: assert property (@(posedge CLK) disable iff (RST)
        cur.st == dpsc_pkg::ST_FAULT && clr_edge && bus.clearable && !bus.fault_in
        |=> cur.st == dpsc_pkg::ST_SW_ON_DIS)
        else $error("fault clear not honoured");
endmodule : dpsc_fsm

// [tb/dpsc_host.sv]
// Host model issuing object requests to the drive block.
// Assumes each taken request is answered within a few cycles.
`timescale 1ns/1ps
module dpsc_host (
    input  wire logic        CLK,
    input  wire logic        OBJ_ACK,
    input  wire logic        OBJ_ERR,
    input  wire logic [15:0] OBJ_RDATA,
    output logic             OBJ_REQ,
    output logic             OBJ_WRITE,
    output logic      [15:0] OBJ_INDEX,
    output logic      [15:0] OBJ_WDATA
);
    initial {OBJ_REQ, OBJ_WRITE, OBJ_INDEX, OBJ_WDATA} = '0;
    // One request; released fields show the inverse so stale use is seen
    task automatic access(input logic wr, input logic [15:0] idx, input logic [15:0] wd,
                          output logic err, output logic [15:0] rd);
        int n;
        n = 0;
        @(posedge CLK);
        OBJ_REQ   <= 1'b1;
        OBJ_WRITE <= wr;
        OBJ_INDEX <= idx;
        OBJ_WDATA <= wd;
        @(posedge CLK);
        OBJ_REQ   <= 1'b0;
        OBJ_WRITE <= ~wr;
        OBJ_INDEX <= ~idx;
        OBJ_WDATA <= ~wd;
        #1;
        // Bounded wait, a lost answer reads as an error
        while (OBJ_ACK !== 1'b1 && n < 8)
        begin
            @(posedge CLK);
            #1;
            n++;
        end
        err = (OBJ_ACK === 1'b1) ? OBJ_ERR : 1'b1;
        rd  = OBJ_RDATA;
    endtask : access
endmodule : dpsc_host

// [tb/dpsc_bench.sv]
// Self-checking bench for the drive power state control block.
// Assumes the host model owns the object port, the bench all else.
`timescale 1ns/1ps
module dpsc_bench;
    logic        clk, rst, req, wr, ack, err, lv, flt, fclr, rdone, sdone, volt;
    logic        sync, warn, goal, lim, cl, halt;
    logic [15:0] idx, wd, rdat, rep;
    logic [31:0] le;
    logic [7:0]  mode;
    logic [1:0]  mst;
    logic [3:0]  mctl;
    logic [2:0]  pst;
    int          num_errors, tests_run, cycles;
    dpsc_top dut (.CLK(clk), .RST(rst), .OBJ_REQ(req), .OBJ_WRITE(wr), .OBJ_INDEX(idx),
        .OBJ_WDATA(wd), .OBJ_ACK(ack), .OBJ_ERR(err), .OBJ_RDATA(rdat), .ERR_LOG_VALID(lv),
        .ERR_LOG_ENTRY(le), .FAULT_IN(flt), .FAULT_CLEARABLE(fclr), .REACTION_DONE(rdone),
        .STOP_DONE(sdone), .VOLTAGE_OK(volt), .BUS_SYNC(sync), .WARNING_IN(warn),
        .GOAL_REACHED(goal), .LIMIT_HIT(lim), .CLOSED_LOOP_ON(cl), .OP_MODE(mode),
        .MODE_STATUS(mst), .HALT_REQ(halt), .MODE_CTRL(mctl), .STATE_REPORT(rep),
        .POWER_STATE(pst));
    dpsc_host host (.CLK(clk), .OBJ_ACK(ack), .OBJ_ERR(err), .OBJ_RDATA(rdat),
        .OBJ_REQ(req), .OBJ_WRITE(wr), .OBJ_INDEX(idx), .OBJ_WDATA(wd));
    // 200 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // One access; data is zero on a write or a refusal
    task automatic acc(input logic w, input logic [15:0] i, input logic [15:0] d,
                       input logic xe, input logic [15:0] xd);
        logic        e;
        logic [15:0] r;
        host.access(w, i, d, e, r);
        chk("refusal", {15'h0, xe}, {15'h0, e});
        chk("read data", xd, r);
    endtask : acc
    // Command write, let machine and report settle, then read report
    task automatic st(input logic [15:0] c, input logic [15:0] x);
        acc(1'b1, 16'h6040, c, 1'b0, 16'h0000);
        repeat (4) @(posedge clk);
        acc(1'b0, 16'h6041, 16'h0000, 1'b0, x);
    endtask : st
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : wrap_up
    // Whole run is under 1000 cycles, so 5000 means a hang
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            num_errors++;
            wrap_up();
        end
    end
    initial
    begin
        {num_errors, tests_run, cycles} = '0;
        {lv, le, flt, fclr, rdone, sdone, warn, goal, mode} = '0;
        {rst, volt, sync, lim, cl, mst} = {5'h1f, 2'h1};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        acc(1'b0, 16'h603f, 16'h0000, 1'b0, 16'h0000);
        acc(1'b0, 16'h6040, 16'h0000, 1'b0, 16'h0000);
        acc(1'b0, 16'h6041, 16'h0000, 1'b0, 16'h1b50);
        st(16'h0006, 16'h1b31);
        st(16'h0007, 16'h1b33);
        st(16'h000f, 16'h9b37);
        st(16'h000b, 16'h1b17);
        @(posedge clk) sdone <= 1'b1;
        @(posedge clk) sdone <= 1'b0;
        st(16'h000b, 16'h1b50);
        @(posedge clk) flt <= 1'b1;
        st(16'h000b, 16'h1b3f);
        @(posedge clk) rdone <= 1'b1;
        @(posedge clk) rdone <= 1'b0;
        st(16'h000b, 16'h1b38);
        @(posedge clk) {flt, fclr} <= 2'b01;
        st(16'h0080, 16'h1b50);
        @(posedge clk) {lv, le} <= {1'b1, 32'hcafe0a5c};
        @(posedge clk) lv <= 1'b0;
        acc(1'b0, 16'h603f, 16'h0000, 1'b0, 16'h0a5c);
        acc(1'b1, 16'h603f, 16'hffff, 1'b1, 16'h0000);
        acc(1'b1, 16'h6041, 16'hffff, 1'b1, 16'h0000);
        acc(1'b0, 16'h6042, 16'h0000, 1'b1, 16'h0000);
        // Halt only in the five listed mode codes
        for (int m = 0; m < 8; m++)
        begin
            @(posedge clk) mode <= 8'(m);
            acc(1'b1, 16'h6040, 16'h0350, 1'b0, 16'h0000);
            repeat (3) @(posedge clk);
            chk("halt", {15'h0, m inside {1, 2, 3, 4, 7}}, {15'h0, halt});
            chk("mode ctrl", 16'h000d, {12'h0, mctl});
        end
        @(posedge clk) {warn, goal, sync, lim, mst} <= {4'b1100, 2'h2};
        repeat (6) @(posedge clk);
        st(16'h0000, 16'h26d0);
        // Bus lock returns through both synchroniser stages
        @(posedge clk) sync <= 1'b1;
        repeat (5) @(posedge clk);
        chk("report pin", 16'h27d0, rep);
        chk("power state", 16'h0001, {13'h0, pst});
        wrap_up();
    end
endmodule : dpsc_bench
